// [pin_function_mux_and_irq_pins.sv]
// pin function multiplexer with six configurable external interrupt lines
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_params.svh"

// Function
// - select low normal pins, high alternate set
// - alternate set maps pads onto test port
// - soft turn-off level survives system reset
// - first four lines: interrupt or gpio
// - fifth and sixth lines offer same choice
// - level, rising or falling detection per line
// - reset leaves lines gpio inputs, driver off
module pin_function_mux_and_irq_pins #(
  parameter int LINES = 6  // number of configurable interrupt lines
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,                  // power-on reset, only for soft turn-off
  // pin set selection and shared pads
  input wire logic pin_set_select_in,         // low normal, high alternate
  input wire logic [7:0] shared_pad_in,       // levels seen on the shared pads
  output logic [7:0] shared_pad_out,          // levels driven on the shared pads
  output logic [7:0] shared_pad_oe_n_out,     // low while a shared pad is driven
  // normal function side
  output logic [7:0] normal_func_out,         // pad levels for the normal functions
  input wire logic [7:0] normal_drive_in,     // normal functions' output levels
  input wire logic [7:0] normal_oe_n_in,      // normal functions' enables, low drives
  // alternate function side
  output logic jtag_trst_n_out,
  output logic jtag_tms_out,
  output logic jtag_tck_out,
  output logic jtag_tdi_out,
  input wire logic jtag_tdo_in,
  output logic signal_core_debug_enable_out,
  output logic control_core_debug_enable_out,
  output logic alt_reset_n_out,               // alternate reset input, active low
  // soft turn-off output
  input wire logic soft_off_wr_in,            // write strobe for the soft turn-off level
  input wire logic soft_off_data_in,          // level to be written
  output logic soft_turn_off_output_out,
  // interrupt line configuration
  input wire logic cfg_wr_in,                 // loads all line settings at once
  input wire logic [LINES-1:0] cfg_irq_en_in,
  input wire logic [2*LINES-1:0] cfg_mode_in, // two bits per line
  input wire logic [LINES-1:0] cfg_dir_out_in,
  input wire logic [LINES-1:0] cfg_out_val_in,
  // interrupt line pads and results
  input wire logic [LINES-1:0] line_pad_in,
  output logic [LINES-1:0] line_pad_out,
  output logic [LINES-1:0] line_pad_oe_n_out,
  output logic [LINES-1:0] general_purpose_input_out, // synchronised pad levels
  output logic [LINES-1:0] irq_request_out    // level or one-cycle pulse by mode
);
  // line configuration registers
  logic [LINES-1:0] irq_en_q, irq_en_d;
  logic [LINES-1:0] dir_out_q, dir_out_d;
  logic [LINES-1:0] out_val_q, out_val_d;
  pin_mux_pkg::irq_mode_t mode_q [LINES];
  pin_mux_pkg::irq_mode_t mode_d [LINES];
  // soft turn-off level
  logic soft_off_q, soft_off_d;

  // next configuration; an illegal mode code falls back to level sensing
  always_comb begin
    irq_en_d = irq_en_q;
    dir_out_d = dir_out_q;
    out_val_d = out_val_q;
    for (int i = 0; i < LINES; i++) begin
      mode_d[i] = mode_q[i];
    end
    if (cfg_wr_in) begin
      irq_en_d = cfg_irq_en_in;
      dir_out_d = cfg_dir_out_in;
      out_val_d = cfg_out_val_in;
      for (int i = 0; i < LINES; i++) begin
        unique case (cfg_mode_in[2*i +: 2])
          2'h0: mode_d[i] = pin_mux_pkg::IRQ_LEVEL;
          2'h1: mode_d[i] = pin_mux_pkg::IRQ_RISE;
          2'h2: mode_d[i] = pin_mux_pkg::IRQ_FALL;
          default: mode_d[i] = pin_mux_pkg::IRQ_LEVEL;
        endcase
      end
    end
  end

  // configuration registers; reset gives gpio inputs with drivers off
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_en_q <= `RST_IRQ_EN;
      dir_out_q <= `RST_DIR_OUT;
      out_val_q <= `RST_OUT_VAL;
      for (int i = 0; i < LINES; i++) begin
        mode_q[i] <= pin_mux_pkg::IRQ_LEVEL;
      end
    end else begin
      irq_en_q <= irq_en_d;
      dir_out_q <= dir_out_d;
      out_val_q <= out_val_d;
      for (int i = 0; i < LINES; i++) begin
        mode_q[i] <= mode_d[i];
      end
    end
  end

  // soft turn-off next value: only a write changes it
  always_comb begin
    soft_off_d = soft_off_q;  // hold by default
    if (soft_off_wr_in) begin
      soft_off_d = soft_off_data_in;
    end
  end

  // the system reset is deliberately not wired here; only power-on sets it
  // trade-off: a defined power-up level costs one extra reset input, but a
  // system reset in mid-run must never switch the supply control off
  always_ff @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      soft_off_q <= `RST_SOFT_OFF;
    end else begin
      soft_off_q <= soft_off_d;
    end
  end

  // the level leaves straight from the flop, so it never glitches
  assign soft_turn_off_output_out = soft_off_q;

  // one line module per interrupt line
  for (genvar g = 0; g < LINES; g++) begin : g_line
    irq_line_if lif();
    assign lif.irq_en = irq_en_q[g];
    assign lif.mode = mode_q[g];
    assign lif.dir_out = dir_out_q[g];
    assign lif.out_val = out_val_q[g];
    assign lif.pad_in = line_pad_in[g];
    irq_line u_line (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .bus(lif.line)
    );
    assign line_pad_out[g] = lif.pad_out;
    assign line_pad_oe_n_out[g] = lif.pad_oe_n;
    assign general_purpose_input_out[g] = lif.general_purpose_input;
    assign irq_request_out[g] = lif.req;
  end

  // shared pad routing; the select is static, so no glitch care is taken
  // beyond giving the unselected side its idle levels
  always_comb begin
    if (pin_set_select_in) begin
      // alternate set: test port, debug enables and reset input
      normal_func_out = `IDLE_NORMAL_IN;
      shared_pad_out = 8'h00;
      shared_pad_oe_n_out = 8'hFF;
      shared_pad_out[`PAD_IDX_TXD] = jtag_tdo_in;
      shared_pad_oe_n_out[`PAD_IDX_TXD] = 1'b0;
      jtag_trst_n_out = shared_pad_in[`PAD_IDX_IRQ7];
      jtag_tms_out = shared_pad_in[`PAD_IDX_IRQ8];
      signal_core_debug_enable_out = shared_pad_in[`PAD_IDX_KEYPAD_ROW_SIX];
      jtag_tck_out = shared_pad_in[`PAD_IDX_KEYPAD_ROW_SEVEN];
      jtag_tdi_out = shared_pad_in[`PAD_IDX_RXD];
      alt_reset_n_out = shared_pad_in[`PAD_IDX_RTS];
      control_core_debug_enable_out = shared_pad_in[`PAD_IDX_CTS];
    end else begin
      // normal set: interrupt, keypad and serial port functions own the pads
      normal_func_out = shared_pad_in;
      shared_pad_out = normal_drive_in;
      shared_pad_oe_n_out = normal_oe_n_in;
      jtag_trst_n_out = `IDLE_LOW;             // hold the test port in reset
      jtag_tms_out = `IDLE_HIGH;
      signal_core_debug_enable_out = `IDLE_LOW;
      jtag_tck_out = `IDLE_LOW;
      jtag_tdi_out = `IDLE_HIGH;
      alt_reset_n_out = `IDLE_HIGH;
      control_core_debug_enable_out = `IDLE_LOW;
    end
  end

  // normal select passes every pad through untouched
  AST_NORMAL_PASS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pin_set_select_in |-> (normal_func_out == shared_pad_in &&
    shared_pad_oe_n_out == normal_oe_n_in)) else $error("normal routing broken");
  // normal select keeps the test port quiet and passes the normal drive levels
  AST_NORMAL_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pin_set_select_in |-> (shared_pad_out == normal_drive_in &&
    jtag_trst_n_out == `IDLE_LOW && jtag_tck_out == `IDLE_LOW &&
    alt_reset_n_out == `IDLE_HIGH))
    else $error("normal set leaks test port levels");
  // alternate select drives transmit pad from the test data output
  AST_ALT_TDO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pin_set_select_in |-> (shared_pad_out[`PAD_IDX_TXD] == jtag_tdo_in &&
    !shared_pad_oe_n_out[`PAD_IDX_TXD] && alt_reset_n_out == shared_pad_in[`PAD_IDX_RTS]))
    else $error("alternate routing broken");
  // alternate select drives no other pad and idles the normal side
  AST_ALT_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pin_set_select_in |-> (shared_pad_oe_n_out == 8'hEF &&
    normal_func_out == `IDLE_NORMAL_IN &&
    jtag_tck_out == shared_pad_in[`PAD_IDX_KEYPAD_ROW_SEVEN]))
    else $error("alternate set drives a wrong pad");
  // soft turn-off holds through system reset and without writes
  AST_SOFT_OFF_HOLD: assert property (@(posedge clk_in) disable iff (!por_n_in)
    !soft_off_wr_in |=> $stable(soft_turn_off_output_out))
    else $error("soft turn-off changed without a write");
  // the first edge after reset sees gpio inputs only
  AST_RESET_GPIO_IN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(!rst_n_in) |-> (irq_en_q == '0 && line_pad_oe_n_out == '1))
    else $error("line not a gpio input after reset");
  // no request is left over from before a reset
  AST_RESET_QUIET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(!rst_n_in) |-> irq_request_out == '0)
    else $error("request pending right after reset");
  // a configuration strobe loads the interrupt enables and directions
  AST_CFG_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_wr_in |=> (irq_en_q == $past(cfg_irq_en_in) &&
    dir_out_q == $past(cfg_dir_out_in)))
    else $error("line configuration not loaded");
  // the spare mode code must fall back to level sensing
  AST_MODE_LEGAL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_wr_in && cfg_mode_in[1:0] == 2'h3) |=> mode_q[0] == pin_mux_pkg::IRQ_LEVEL)
    else $error("spare mode code not taken as level");
  // sixth line drives as a gpio output when configured so
  AST_UPPER_GPIO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_wr_in && !cfg_irq_en_in[LINES-1] && cfg_dir_out_in[LINES-1])
    |=> (!line_pad_oe_n_out[LINES-1] &&
    line_pad_out[LINES-1] == $past(cfg_out_val_in[LINES-1])))
    else $error("upper line gpio output wrong");
endmodule : pin_function_mux_and_irq_pins
`default_nettype wire

// [pin_mux_params.svh]
// idle levels, reset values and pad indices for the pin function multiplexer
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// positions of the shared pads inside the eight-bit shared pad bundle
`define PAD_IDX_IRQ7 0
`define PAD_IDX_IRQ8 1
`define PAD_IDX_KEYPAD_ROW_SIX 2
`define PAD_IDX_KEYPAD_ROW_SEVEN 3
`define PAD_IDX_TXD 4
`define PAD_IDX_RXD 5
`define PAD_IDX_RTS 6
`define PAD_IDX_CTS 7

// idle levels handed to whichever function set is not selected
`define IDLE_NORMAL_IN 8'hFF
`define IDLE_HIGH 1'h1
`define IDLE_LOW 1'h0

// reset values of the line configuration and the soft turn-off level
`define RST_IRQ_EN 6'h00
`define RST_DIR_OUT 6'h00
`define RST_OUT_VAL 6'h00
`define RST_SOFT_OFF 1'h0

`endif

// [pin_mux_pkg.sv]
// types shared by the pin function multiplexer and its interrupt lines
package pin_mux_pkg;
  // detection mode of one interrupt line
  typedef enum logic [1:0] {
    IRQ_LEVEL,
    IRQ_RISE,
    IRQ_FALL
  } irq_mode_t;
endpackage : pin_mux_pkg

// [irq_line_if.sv]
// bundle between the multiplexer top and one external interrupt line
`timescale 1ns/1ps
`default_nettype none
interface irq_line_if;
  logic irq_en;                   // line works as an interrupt input
  pin_mux_pkg::irq_mode_t mode;   // detection mode
  logic dir_out;                  // gpio direction, 1 drives the pad
  logic out_val;                  // gpio output level
  logic pad_in;                   // pad level
  logic pad_out;                  // level driven on the pad
  logic pad_oe_n;                 // low while the pad is driven
  logic general_purpose_input;    // synchronised pad level
  logic req;                      // interrupt request
  modport line (input irq_en, input mode, input dir_out, input out_val, input pad_in,
                output pad_out, output pad_oe_n, output general_purpose_input,
                output req);
  modport ctrl (output irq_en, output mode, output dir_out, output out_val,
                output pad_in, input pad_out, input pad_oe_n,
                input general_purpose_input, input req);
endinterface : irq_line_if
`default_nettype wire

// [irq_line.sv]
// one external interrupt line: synchroniser, detector and gpio driver
`timescale 1ns/1ps
`default_nettype none
module irq_line (
  input wire logic clk_in,
  input wire logic rst_n_in,
  irq_line_if.line bus
);
  logic sync1_q, sync1_d; // first stage, read only by the second
  logic sync2_q, sync2_d; // synchronised pad level
  logic prev_q, prev_d;   // last synchronised level for edge detection
  logic req_q, req_d;     // registered request

  // next values: the detector only looks at the second stage and its history
  always_comb begin
    sync1_d = bus.pad_in;
    sync2_d = sync1_q;
    prev_d = sync2_q;
    req_d = 1'b0;
    if (bus.irq_en) begin
      unique case (bus.mode)
        // pins are pulled up, so the level request is active low
        pin_mux_pkg::IRQ_LEVEL: req_d = ~sync2_q;
        pin_mux_pkg::IRQ_RISE: req_d = sync2_q & ~prev_q;
        pin_mux_pkg::IRQ_FALL: req_d = ~sync2_q & prev_q;
        default: req_d = 1'b0;                               // illegal code raises nothing
      endcase
    end
  end

  // registers; sampling flops reset to the pulled-up idle level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
      req_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      req_q <= req_d;
    end
  end

  // an interrupt line never drives; otherwise it is gpio by direction
  assign bus.pad_oe_n = bus.irq_en | ~bus.dir_out;
  assign bus.pad_out = bus.out_val;
  assign bus.general_purpose_input = sync2_q;
  assign bus.req = req_q;

  // interrupt mode keeps the driver off
  AST_IRQ_NO_DRIVE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bus.irq_en |-> bus.pad_oe_n) else $error("irq line drives its pad");
  // a rising edge gives exactly one cycle of request
  AST_RISE_ONE_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bus.mode == pin_mux_pkg::IRQ_RISE && req_q) |=> !req_q)
    else $error("rise request longer than one cycle");
  // a falling edge seen after two stages raises a request
  AST_FALL_CAUSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bus.irq_en && bus.mode == pin_mux_pkg::IRQ_FALL && prev_q && !sync2_q) |=> req_q)
    else $error("falling edge missed");
  // pad low at three edges: two sync stages, then the request one edge later
  AST_LEVEL_LATENCY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bus.irq_en && bus.mode == pin_mux_pkg::IRQ_LEVEL && !bus.pad_in)[*3] |=> req_q)
    else $error("level request late");
endmodule : irq_line
`default_nettype wire

// [pad_partner.sv]
// model of the outside pads: pull-ups plus an optional outside driver
`timescale 1ns/1ps
`default_nettype none
module pad_partner #(
  parameter int W = 8  // number of pads modelled
) (
  input wire logic [W-1:0] drv_in,    // level the design drives
  input wire logic [W-1:0] oe_n_in,   // low while the design drives
  input wire logic [W-1:0] ext_in,    // outside driver level
  input wire logic [W-1:0] ext_en_in, // outside driver switched on
  output logic [W-1:0] level_out      // resolved pad level
);
  // design drive wins; a pad nobody drives floats up to its pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_out[i] = !oe_n_in[i] ? drv_in[i] : (ext_en_in[i] ? ext_in[i] : 1'b1);
    end
  end
endmodule : pad_partner
`default_nettype wire

// [tb.sv]
// self-checking bench for the pin function multiplexer and interrupt lines
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module tb;
  logic clk_in = 1'b0, rst_n_in = 1'b0, por_n_in = 1'b0, pin_set_select_in = 1'b0;
  logic [7:0] normal_drive_in = 8'h00, normal_oe_n_in = 8'hFF, sh_ext = 8'hFF;
  logic jtag_tdo_in = 1'b0, soft_off_wr_in = 1'b0, soft_off_data_in = 1'b0, cfg_wr_in = 1'b0;
  logic [5:0] cfg_irq_en_in = 6'h00, cfg_dir_out_in = 6'h00, cfg_out_val_in = 6'h00;
  logic [11:0] cfg_mode_in = 12'h000;
  logic [5:0] ln_ext = 6'h3F, ln_en = 6'h00; // outside drivers on the line pads
  logic [7:0] shared_pad_in, shared_pad_out, shared_pad_oe_n_out, normal_func_out;
  logic jtag_trst_n_out, jtag_tms_out, jtag_tck_out, jtag_tdi_out, alt_reset_n_out;
  logic signal_core_debug_enable_out, control_core_debug_enable_out, soft_turn_off_output_out;
  logic [5:0] line_pad_in, line_pad_out, line_pad_oe_n_out, general_purpose_input_out;
  logic [5:0] irq_request_out;
  int err_total = 0, tests_run = 0;
  logic [31:0] seed = 32'h8329; // fixed seed keeps runs repeatable
  logic [31:0] r;
  logic [30:0] mux_got, mux_want; // packed mux outputs and their expected values
  int cnt [6];
  // free-running system clock, 8 ns period
  always #4 clk_in = ~clk_in;
  pin_function_mux_and_irq_pins #(.LINES(6)) dut_u (.clk_in, .rst_n_in, .por_n_in,
    .pin_set_select_in, .shared_pad_in, .shared_pad_out, .shared_pad_oe_n_out,
    .normal_func_out, .normal_drive_in, .normal_oe_n_in, .jtag_trst_n_out, .jtag_tms_out,
    .jtag_tck_out, .jtag_tdi_out, .jtag_tdo_in, .signal_core_debug_enable_out,
    .control_core_debug_enable_out, .alt_reset_n_out, .soft_off_wr_in, .soft_off_data_in,
    .soft_turn_off_output_out, .cfg_wr_in, .cfg_irq_en_in, .cfg_mode_in, .cfg_dir_out_in,
    .cfg_out_val_in, .line_pad_in, .line_pad_out, .line_pad_oe_n_out,
    .general_purpose_input_out, .irq_request_out);
  pad_partner #(.W(8)) sh_u (.drv_in(shared_pad_out), .oe_n_in(shared_pad_oe_n_out),
    .ext_in(sh_ext), .ext_en_in(8'hFF), .level_out(shared_pad_in));
  pad_partner #(.W(6)) ln_u (.drv_in(line_pad_out), .oe_n_in(line_pad_oe_n_out),
    .ext_in(ln_ext), .ext_en_in(ln_en), .level_out(line_pad_in));
  // xorshift source for all random stimulus
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // expected mux outputs; unselected side sits at its idle levels
  function automatic logic [30:0] exp_mux(input logic s, input logic [7:0] p, d, o,
                                          input logic t);
    if (!s) return {d, o, p, 7'b0101001};
    return {3'b000, t, 4'h0, 8'hEF, 8'hFF, p[0], p[1], p[3], p[5], p[2], p[7], p[6]};
  endfunction : exp_mux
  // load all six line settings with one strobe
  task automatic cfg(input logic [5:0] e, input logic [1:0] m, input logic [5:0] d, v);
    @(posedge clk_in);
    cfg_wr_in <= 1'b1;
    cfg_irq_en_in <= e;
    cfg_mode_in <= {6{m}};
    cfg_dir_out_in <= d;
    cfg_out_val_in <= v;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
    @(negedge clk_in);
  endtask : cfg
  // one write of the soft turn-off level
  task automatic soft_off(input logic v);
    @(posedge clk_in);
    soft_off_wr_in <= 1'b1;
    soft_off_data_in <= v;
    @(posedge clk_in);
    soft_off_wr_in <= 1'b0;
    @(negedge clk_in);
  endtask : soft_off
  task automatic print_verdict();
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    por_n_in <= 1'b1;
    repeat (14) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(negedge clk_in);
    `CHK(line_pad_oe_n_out, 6'h3F)
    `CHK(irq_request_out, 6'h00)
    `CHK(general_purpose_input_out, 6'h3F)
    // soft turn-off level must ride through a system reset, both values
    for (int k = 0; k < 2; k++) begin
      soft_off(k[0] ^ 1'b1);
      @(posedge clk_in) rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(negedge clk_in);
      `CHK(soft_turn_off_output_out, k[0] ^ 1'b1)
    end
    // random pads and drives, select alternating so both sets are seen
    for (int i = 0; i < 40; i++) begin
      r = xs();
      @(posedge clk_in);
      pin_set_select_in <= i[0];
      sh_ext <= r[15:8];
      normal_drive_in <= r[23:16];
      normal_oe_n_in <= r[31:24];
      jtag_tdo_in <= r[1];
      @(negedge clk_in);
      mux_got = {shared_pad_out, shared_pad_oe_n_out, normal_func_out, jtag_trst_n_out,
                 jtag_tms_out, jtag_tck_out, jtag_tdi_out, signal_core_debug_enable_out,
                 control_core_debug_enable_out, alt_reset_n_out};
      mux_want = exp_mux(pin_set_select_in, shared_pad_in, normal_drive_in, normal_oe_n_in,
                         jtag_tdo_in);
      `CHK(mux_got, mux_want)
    end
    // gpio drive and loopback, then interrupt enable must release the driver
    for (int i = 0; i < 8; i++) begin
      r = xs();
      cfg(6'h00, 2'h0, r[5:0], r[13:8]);
      `CHK(line_pad_oe_n_out, ~r[5:0])
      `CHK(line_pad_out, r[13:8])
      repeat (3) @(negedge clk_in);
      `CHK(general_purpose_input_out, (r[5:0] & r[13:8]) | ~r[5:0])
      cfg(r[21:16], 2'h1, r[5:0], r[13:8]);
      `CHK(line_pad_oe_n_out, ~(r[5:0] & ~r[21:16]))
    end
    // every detection code, random enables; count request cycles per line
    ln_en <= 6'h3F;
    for (int m = 0; m < 4; m++) begin
      r = xs();
      cfg(r[5:0], m[1:0], 6'h00, 6'h00);
      repeat (4) @(negedge clk_in);
      for (int j = 0; j < 6; j++) cnt[j] = 0;
      for (int c = 0; c < 16; c++) begin
        @(posedge clk_in) ln_ext <= (c < 5) ? 6'h00 : 6'h3F;
        @(negedge clk_in);
        for (int j = 0; j < 6; j++) if (irq_request_out[j] === 1'b1) cnt[j]++;
        `CHK(irq_request_out & ~r[5:0], 6'h00)
      end
      for (int j = 0; j < 6; j++) begin
        `CHK(cnt[j], !r[j] ? 0 : ((m == 1 || m == 2) ? 1 : 5))
      end
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
